// ### bench/controlled_stop_sequencer_sva.sv
// Checker for the stop sequencer outputs against its stop inputs.
module stop_seq_checker #(
    parameter int unsigned CYC_MS = 100000
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic stop_request_n,
    input wire logic limit_violation,
    input wire logic internal_error,
    input wire logic axis_reset_req,
    input wire logic stop_active_fb,
    input wire logic torque_off_active_fb,
    input wire logic torque_off_cmd,
    input wire logic drive_brake_start,
    input wire logic drive_ignore_setpoints,
    input wire logic fieldbus_brake_start,
    input wire logic axis_reset
);
    localparam longint unsigned RUN_MAX = 64'd120001 * CYC_MS + 64'd8;
    logic [39:0] run_r;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            run_r <= 40'h0;
        end else if (stop_active_fb && !torque_off_active_fb) begin
            run_r <= run_r + 40'h1;
        end else begin
            run_r <= 40'h0;
        end
    end
    pin_stop_a: assert property (!stop_request_n [*5] |-> stop_active_fb)
        else $error("stop request ignored");
    limit_stop_a: assert property (limit_violation |-> ##[1:2] stop_active_fb)
        else $error("limit violation ignored");
    error_stop_a: assert property (internal_error |-> ##[1:2] stop_active_fb)
        else $error("internal error ignored");
    mode_excl_a: assert property (!(drive_brake_start && fieldbus_brake_start))
        else $error("both brake paths started");
    ignore_tracks_a: assert property (drive_ignore_setpoints == drive_brake_start)
        else $error("setpoint ignore wrong");
    fb_nesting_a: assert property (torque_off_active_fb |-> stop_active_fb && torque_off_cmd)
        else $error("feedback mismatch");
    brake_ends_a: assert property (torque_off_active_fb |-> !drive_brake_start)
        else $error("braking during torque-off");
    toff_hold_a: assert property ($fell(torque_off_active_fb) |-> axis_reset)
        else $error("torque-off dropped without reset");
    axis_pulse_a: assert property (axis_reset |-> $past(axis_reset_req) ##1 !axis_reset)
        else $error("axis reset pulse wrong");
    max_time_a: assert property (run_r <= RUN_MAX)
        else $error("stop ran too long");
    cover property ($rose(torque_off_active_fb));
    cover property ($rose(fieldbus_brake_start));
    cover property (axis_reset);
endmodule
bind controlled_stop_sequencer stop_seq_checker #(.CYC_MS(CYC_MS)) chk_i (.pclk, .presetn,
    .stop_request_n, .limit_violation, .internal_error, .axis_reset_req, .stop_active_fb,
    .torque_off_active_fb, .torque_off_cmd, .drive_brake_start, .drive_ignore_setpoints,
    .fieldbus_brake_start, .axis_reset);

// ### bench/controlled_stop_sequencer_tb_top.sv
// Testbench for the stop sequencer: register access and stop sequences.
module controlled_stop_sequencer_tb_top;
    timeunit 1ns;
    timeprecision 1ns;
    import stop_seq_pkg::*;
    logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0;
    logic [11:0] paddr = 12'h0;
    logic [31:0] pwdata = 32'h0, prdata, apos, epos, dramp;
    logic [3:0] pstrb = 4'hf;
    logic sreq_n = 1, treq_n = 1, lim = 0, ierr = 0, arst = 0, slip = 0;
    logic pready, pslverr, cen, sfb, tfb, tcmd, dbs, dis, fbs, axr;
    logic [23:0] spd;
    int fails = 0, checks_done = 0, n;
    logic [11:0] ra [9] = '{ADDR_CTRL, ADDR_TMAX, ADDR_TEMG, ADDR_DECWIN, ADDR_RAMP,
        ADDR_ERAMP, ADDR_VLIM, ADDR_AXIS, 12'h040};
    logic [31:0] rv [9] = '{32'h0, TMAX_MS_RST, TEMG_MS_RST, DECWIN_RST, RAMP_RST,
        RAMP_RST, {8'h0, VLIM_RST}, 32'h0, 32'h0};
    controlled_stop_sequencer #(.CYC_MS(10), .AXIS_SECOND(1'b0)) uut (.pclk, .presetn,
        .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .pslverr,
        .stop_request_n(sreq_n), .torque_off_request_n(treq_n), .limit_violation(lim),
        .internal_error(ierr), .axis_reset_req(arst), .controller_enable(cen),
        .actual_pos(apos), .expected_pos(epos), .motor_speed(spd), .stop_active_fb(sfb),
        .torque_off_active_fb(tfb), .torque_off_cmd(tcmd), .drive_brake_start(dbs),
        .drive_ramp(dramp), .drive_ignore_setpoints(dis), .fieldbus_brake_start(fbs),
        .axis_reset(axr));
    drive_partner far_i (.pclk, .brake_drv(dbs), .brake_bus(fbs), .slip,
        .actual_pos(apos), .expected_pos(epos), .motor_speed(spd), .controller_enable(cen));
    initial forever #5 pclk = ~pclk;
    task report_and_stop;
        $display("checks %0d fails %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            fails++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask
    task acc(input logic w, input logic [11:0] a, input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        if (!w) chk("read data", d, prdata);
        chk("slave error", 32'h0, {31'h0, pslverr});
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task stop_case(input logic [31:0] ctrl, input int trig, input logic [31:0] ramp,
                   input int lo, input int hi);
        acc(1'b1, ADDR_CTRL, ctrl);
        sreq_n <= (trig != 0);
        lim <= (trig == 1);
        ierr <= (trig == 2);
        treq_n <= (trig != 3);
        n = 0;
        while (tfb !== 1'b1 && n < hi) begin
            @(posedge pclk);
            n++;
            if (n == 6 && tfb !== 1'b1) begin
                chk("stop fb", 32'h1, {31'h0, sfb});
                chk("brake paths", {30'h0, !ctrl[0], ctrl[0]}, {30'h0, dbs, fbs});
                chk("ignore", {31'h0, !ctrl[0]}, {31'h0, dis});
                if (!ctrl[0]) chk("ramp", ramp, dramp);
            end
        end
        chk("toff delay ok", 32'h1, {31'h0, n >= lo && n <= hi});
        sreq_n <= 1'b1;
        lim <= 1'b0;
        ierr <= 1'b0;
        treq_n <= 1'b1;
        repeat (5) @(posedge pclk);
        chk("toff held", 32'h3, {30'h0, tfb, tcmd});
        arst <= 1'b1;
        @(posedge pclk);
        arst <= 1'b0;
        @(negedge pclk);
        chk("axis reset", 32'h1, {31'h0, axr});
        repeat (3) @(posedge pclk);
        chk("released", 32'h0, {30'h0, sfb, tfb});
    endtask
    initial begin
        #200000;
        fails++;
        report_and_stop();
    end
    initial begin
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        for (int i = 0; i < 9; i++) acc(1'b0, ra[i], rv[i]);
        acc(1'b1, ADDR_TMAX, 32'h3);
        acc(1'b1, ADDR_TMAX, TMAX_MS_MAX + 32'h1);
        acc(1'b0, ADDR_TMAX, 32'h3);
        acc(1'b1, ADDR_TEMG, 32'h2);
        acc(1'b1, ADDR_RAMP, 32'h5678);
        acc(1'b1, ADDR_ERAMP, 32'h1234);
        acc(1'b1, ADDR_CTRL, 32'h2);
        acc(1'b1, ADDR_RAMP, 32'h1);
        acc(1'b0, ADDR_RAMP, 32'h5678);
        acc(1'b0, ADDR_STATUS, 32'h81);
        stop_case(32'h0, 0, 32'h5678, 30, 40);
        stop_case(32'h0, 1, 32'h1234, 18, 26);
        stop_case(32'h0, 2, 32'h1234, 18, 26);
        stop_case(32'h1, 0, 32'h5678, 30, 40);
        stop_case(32'h10, 3, 32'h5678, 1, 8);
        acc(1'b1, ADDR_VLIM, 32'h3e3);
        stop_case(32'h8, 0, 32'h5678, 6, 20);
        acc(1'b1, ADDR_DECWIN, 32'h5);
        slip <= 1'b1;
        stop_case(32'h2, 0, 32'h5678, 1, 10);
        stop_case(32'h3, 0, 32'h5678, 1, 10);
        stop_case(32'h7, 0, 32'h5678, 1, 10);
        slip <= 1'b0;
        acc(1'b1, ADDR_TMAX, 32'h0);
        stop_case(32'h0, 0, 32'h5678, 1, 8);
        report_and_stop();
    end
endmodule

// ### bench/drive_partner.sv
// Drive model that brakes on command and reports position and speed.
module drive_partner (
    input wire logic pclk,
    input wire logic brake_drv,
    input wire logic brake_bus,
    input wire logic slip,
    output logic [31:0] actual_pos,
    output logic [31:0] expected_pos,
    output logic [23:0] motor_speed,
    output logic controller_enable
);
    timeunit 1ns;
    timeprecision 1ns;
    initial begin
        actual_pos = 32'h0;
        expected_pos = 32'h0;
        motor_speed = 24'h0003e8;
    end
    assign controller_enable = (motor_speed != 24'h0);
    always @(posedge pclk) begin
        if (brake_drv || brake_bus) begin
            motor_speed <= (motor_speed != 24'h0) ? motor_speed - 24'h1 : 24'h0;
        end else begin
            motor_speed <= 24'h0003e8;
        end
        expected_pos <= expected_pos + {8'h0, motor_speed};
        actual_pos <= expected_pos + {8'h0, motor_speed} + (slip ? 32'h64 : 32'h0);
    end
endmodule

// ### pkg/stop_seq_pkg.sv
// Package with register map, field positions, defaults and states of the stop sequencer.
package stop_seq_pkg;
    localparam int unsigned CLK_HZ = 100_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned CYC_PER_MS = CLK_HZ / MS_PER_S;
    localparam logic [11:0] ADDR_CTRL = 12'h000;
    localparam logic [11:0] ADDR_TMAX = 12'h004;
    localparam logic [11:0] ADDR_TEMG = 12'h008;
    localparam logic [11:0] ADDR_DECWIN = 12'h00c;
    localparam logic [11:0] ADDR_RAMP = 12'h010;
    localparam logic [11:0] ADDR_ERAMP = 12'h014;
    localparam logic [11:0] ADDR_VLIM = 12'h018;
    localparam logic [11:0] ADDR_STATUS = 12'h01c;
    localparam logic [11:0] ADDR_AXIS = 12'h020;
    localparam int CTRL_CTL_MODE = 0;
    localparam int CTRL_SUPV_EN = 1;
    localparam int CTRL_ERR_ESTOP = 2;
    localparam int CTRL_VLIM_EN = 3;
    localparam int CTRL_TOREQ_EN = 4;
    localparam int CTRL_AXIS_SEL = 5;
    localparam logic [31:0] TMAX_MS_MAX = 32'h0001d4c0;
    localparam logic [31:0] TMAX_MS_RST = 32'h00000064;
    localparam logic [31:0] TEMG_MS_RST = 32'h00000032;
    localparam logic [31:0] DECWIN_MAX = 32'h7fffffff;
    localparam logic [31:0] DECWIN_RST = 32'h00000000;
    localparam logic [31:0] RAMP_MIN_SUPV = 32'h00000002;
    localparam logic [31:0] RAMP_RST = 32'h02faf080;
    localparam logic [23:0] VLIM_RST = 24'h000154;
    typedef enum logic [4:0] {
        ST_IDLE = 5'b00001,
        ST_DRIVE = 5'b00010,
        ST_CTRL = 5'b00100,
        ST_TOFF = 5'b01000,
        ST_WAIT = 5'b10000
    } seq_state_t;
endpackage

// ### rtl/controlled_stop_sequencer.sv
// Controlled-stop sequencer for one drive axis with an APB register file.
//
// The APB register port and the register addresses were decided locally.
module controlled_stop_sequencer #(
    parameter int unsigned CYC_MS = stop_seq_pkg::CYC_PER_MS,
    parameter logic AXIS_SECOND = 1'b0
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [3:0] pstrb,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic stop_request_n,
    input wire logic torque_off_request_n,
    input wire logic limit_violation,
    input wire logic internal_error,
    input wire logic axis_reset_req,
    input wire logic controller_enable,
    input wire logic [31:0] actual_pos,
    input wire logic [31:0] expected_pos,
    input wire logic [23:0] motor_speed,
    output logic stop_active_fb,
    output logic torque_off_active_fb,
    output logic torque_off_cmd,
    output logic drive_brake_start,
    output logic [31:0] drive_ramp,
    output logic drive_ignore_setpoints,
    output logic fieldbus_brake_start,
    output logic axis_reset
);
    import stop_seq_pkg::*;

    logic [1:0] stop_sync_r;
    logic [1:0] toff_sync_r;
    logic [31:0] ctrl_r;
    logic [31:0] tmax_r;
    logic [31:0] temg_r;
    logic [31:0] decwin_r;
    logic [31:0] ramp_r;
    logic [31:0] eramp_r;
    logic [23:0] vlim_r;
    logic reject_r;
    logic err_stop_r;
    logic supv_fault_r;
    logic [31:0] ms_r;
    logic [31:0] sub_r;
    seq_state_t state_r;
    seq_state_t state_nxt;
    logic stop_req;
    logic toff_req;
    logic err_evt;
    logic wr_en;
    logic [31:0] wmask;
    logic [31:0] pos_diff;
    logic supv_bad;
    logic auto_off;
    logic tmax_hit;
    logic temg_hit;
    logic stopping;
    logic ramp_ok;

    // The stop and torque-off request pins cross into the clock domain through two flip-flops.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_sync_r <= 2'b11;
            toff_sync_r <= 2'b11;
        end else begin
            stop_sync_r <= {stop_sync_r[0], stop_request_n};
            toff_sync_r <= {toff_sync_r[0], torque_off_request_n};
        end
    end

    assign stop_req = ~stop_sync_r[1];
    assign toff_req = ~toff_sync_r[1] & ctrl_r[CTRL_TOREQ_EN];
    assign err_evt = limit_violation | internal_error;

    assign pready = 1'b1;
    assign pslverr = 1'b0;
    assign wr_en = psel & penable & pwrite;
    always_comb begin
        wmask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    end

    // Ramp values below the minimum are refused while supervision is on.
    assign ramp_ok = ~ctrl_r[CTRL_SUPV_EN] | ((pwdata & wmask) >= RAMP_MIN_SUPV);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_r <= 32'h00000000;
            tmax_r <= TMAX_MS_RST;
            temg_r <= TEMG_MS_RST;
            decwin_r <= DECWIN_RST;
            ramp_r <= RAMP_RST;
            eramp_r <= RAMP_RST;
            vlim_r <= VLIM_RST;
            reject_r <= 1'b0;
        end else if (wr_en && state_r == ST_IDLE) begin
            if (paddr == ADDR_CTRL) begin
                ctrl_r <= ((ctrl_r & ~wmask) | (pwdata & wmask)) & 32'h0000001f;
            end else if (paddr == ADDR_TMAX) begin
                if (pwdata <= TMAX_MS_MAX) begin
                    tmax_r <= pwdata;
                end
            end else if (paddr == ADDR_TEMG) begin
                if (pwdata <= TMAX_MS_MAX) begin
                    temg_r <= pwdata;
                end
            end else if (paddr == ADDR_DECWIN) begin
                if (pwdata <= DECWIN_MAX) begin
                    decwin_r <= pwdata;
                end
            end else if (paddr == ADDR_RAMP) begin
                if (ramp_ok && pwdata <= DECWIN_MAX) begin
                    ramp_r <= pwdata;
                end
                reject_r <= ~ramp_ok;
            end else if (paddr == ADDR_ERAMP) begin
                if (ramp_ok && pwdata <= DECWIN_MAX) begin
                    eramp_r <= pwdata;
                end
                reject_r <= ~ramp_ok;
            end else if (paddr == ADDR_VLIM) begin
                vlim_r <= pwdata[23:0];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h00000000;
        end else if (psel && !penable && !pwrite) begin
            if (paddr == ADDR_CTRL) begin
                prdata <= {26'h0000000, AXIS_SECOND, ctrl_r[4:0]};
            end else if (paddr == ADDR_TMAX) begin
                prdata <= tmax_r;
            end else if (paddr == ADDR_TEMG) begin
                prdata <= temg_r;
            end else if (paddr == ADDR_DECWIN) begin
                prdata <= decwin_r;
            end else if (paddr == ADDR_RAMP) begin
                prdata <= ramp_r;
            end else if (paddr == ADDR_ERAMP) begin
                prdata <= eramp_r;
            end else if (paddr == ADDR_VLIM) begin
                prdata <= {8'h00, vlim_r};
            end else if (paddr == ADDR_STATUS) begin
                prdata <= {24'h000000, reject_r, supv_fault_r, err_stop_r, state_r};
            end else if (paddr == ADDR_AXIS) begin
                prdata <= {31'h00000000, AXIS_SECOND};
            end else begin
                prdata <= 32'h00000000;
            end
        end
    end

    assign stopping = (state_r == ST_DRIVE) || (state_r == ST_CTRL);

    // Millisecond timer counted in whole cycles; partial ms are not counted.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sub_r <= 32'h00000000;
            ms_r <= 32'h00000000;
        end else if (!stopping) begin
            sub_r <= 32'h00000000;
            ms_r <= 32'h00000000;
        end else if (sub_r == CYC_MS - 1) begin
            sub_r <= 32'h00000000;
            ms_r <= ms_r + 32'h00000001;
        end else begin
            sub_r <= sub_r + 32'h00000001;
        end
    end

    assign tmax_hit = stopping && (ms_r >= tmax_r);
    assign temg_hit = stopping && err_stop_r && (ms_r >= temg_r);

    assign pos_diff = (actual_pos >= expected_pos) ? actual_pos - expected_pos
                                                    : expected_pos - actual_pos;
    assign supv_bad = stopping && ctrl_r[CTRL_SUPV_EN] && (pos_diff > decwin_r);

    // Speed threshold, or controller enable loss when the threshold is zero.
    assign auto_off = stopping && ctrl_r[CTRL_VLIM_EN] &&
                      ((vlim_r == 24'h000000) ? ~controller_enable
                                              : (motor_speed < vlim_r));

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= ST_IDLE;
        end else begin
            state_r <= state_nxt;
        end
    end

    always_comb begin
        state_nxt = state_r;
        case (state_r)
            ST_IDLE: begin
                if (toff_req) begin
                    state_nxt = ST_TOFF;
                end else if (stop_req || err_evt) begin
                    state_nxt = ctrl_r[CTRL_CTL_MODE] ? ST_CTRL : ST_DRIVE;
                end
            end
            ST_DRIVE: begin
                if (toff_req || tmax_hit || temg_hit || auto_off || supv_bad) begin
                    state_nxt = ST_TOFF;
                end
            end
            ST_CTRL: begin
                if (toff_req || tmax_hit || temg_hit || auto_off) begin
                    state_nxt = ST_TOFF;
                end else if (supv_bad) begin
                    state_nxt = ctrl_r[CTRL_ERR_ESTOP] ? ST_DRIVE : ST_TOFF;
                end
            end
            ST_TOFF: begin
                if (!stop_req && !toff_req && !err_evt) begin
                    state_nxt = ST_WAIT;
                end
            end
            ST_WAIT: begin
                if (stop_req || toff_req || err_evt) begin
                    state_nxt = ST_TOFF;
                end else if (axis_reset_req) begin
                    state_nxt = ST_IDLE;
                end
            end
            default: begin
                state_nxt = ST_TOFF;
            end
        endcase
    end

    // Error origin of the stop selects the emergency ramp and its time.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            err_stop_r <= 1'b0;
            supv_fault_r <= 1'b0;
        end else if (state_r == ST_IDLE) begin
            err_stop_r <= err_evt & ~stop_req;
            supv_fault_r <= 1'b0;
        end else if (supv_bad) begin
            err_stop_r <= 1'b1;
            supv_fault_r <= 1'b1;
        end else if (stopping && err_evt) begin
            err_stop_r <= 1'b1;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            stop_active_fb <= 1'b0;
            torque_off_active_fb <= 1'b0;
            torque_off_cmd <= 1'b0;
            drive_brake_start <= 1'b0;
            drive_ramp <= 32'h00000000;
            drive_ignore_setpoints <= 1'b0;
            fieldbus_brake_start <= 1'b0;
            axis_reset <= 1'b0;
        end else begin
            stop_active_fb <= state_nxt != ST_IDLE;
            torque_off_active_fb <= (state_nxt == ST_TOFF) || (state_nxt == ST_WAIT);
            torque_off_cmd <= (state_nxt == ST_TOFF) || (state_nxt == ST_WAIT);
            drive_brake_start <= state_nxt == ST_DRIVE;
            drive_ramp <= (err_stop_r || err_evt || supv_bad) ? eramp_r : ramp_r;
            drive_ignore_setpoints <= state_nxt == ST_DRIVE;
            fieldbus_brake_start <= state_nxt == ST_CTRL;
            axis_reset <= (state_r == ST_WAIT) && (state_nxt == ST_IDLE);
        end
    end
endmodule
